// ===== inc/ebes_pkg.sv
// constants and types for the eviction error sampler
// How it works
// - data ram error input is one bit or four banked bits.
// - tag ram error vector is eight bits, sixteen with sixteen ways.
// - errors are sampled only on the cycle set by programmed ram latency.
// - a dirty eviction reads tag and data rams before line replacement.
// - a captured data, tag or tag parity error cancels the eviction.
// - data parity errors are ignored; eviction is still forwarded.
// - errors for other requesters or slots, and early transients, are ignored.
package ebes_pkg;
  localparam int DATA_BANKS = 4;
  localparam int TAG_WAYS = 16;
  localparam int LAT_W = 3;
  localparam int SLOT_W = 2;
  localparam logic [LAT_W-1:0] LAT_ONE = 3'h1;
  localparam logic [LAT_W-1:0] LAT_ZERO = 3'h0;
  typedef enum logic [1:0] {
    EBES_IDLE = 2'b00,
    EBES_READ = 2'b01,
    EBES_DONE = 2'b10
  } ebes_state_t;
endpackage

// ===== inc/ebes_win_if.sv
// interface carrying one latency-window sample request and its strobe
`timescale 1ns/100ps
interface ebes_win_if;
  logic start;
  logic [ebes_pkg::LAT_W-1:0] lat;
  logic strobe;
  modport ctl (output start, output lat, input strobe);
  modport win (input start, input lat, output strobe);
endinterface

// ===== rtl/ebes_window.sv
// latency counter that strobes on the exact sample cycle of one ram access
`timescale 1ns/100ps
module ebes_window (
  input wire logic clk,
  input wire logic rst,
  ebes_win_if.win w
);
  typedef struct packed {
    logic busy;
    logic [ebes_pkg::LAT_W-1:0] cnt;
    logic strobe;
  } ebes_win_st_t;
  ebes_win_st_t st_ff;
  ebes_win_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe = 1'b0;
    if (w.start) begin
      // latency of zero is treated as one: the ram answers no sooner than next cycle
      nxt_st.busy = 1'b1;
      nxt_st.cnt = (w.lat == ebes_pkg::LAT_ZERO) ? ebes_pkg::LAT_ONE : w.lat;
    end else if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt - ebes_pkg::LAT_ONE;
      if (st_ff.cnt == ebes_pkg::LAT_ONE) begin
        nxt_st.busy = 1'b0;
        nxt_st.strobe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign w.strobe = st_ff.strobe;
endmodule

// ===== rtl/ebes_evict.sv
// eviction buffer error sampling: reads tag and data, cancels only on valid errors
`timescale 1ns/100ps
module ebes_evict (
  input wire logic clk,
  input wire logic rst,
  input wire logic evict_req,
  input wire logic [ebes_pkg::SLOT_W-1:0] evict_slot,
  input wire logic [ebes_pkg::LAT_W-1:0] tag_lat,
  input wire logic [ebes_pkg::LAT_W-1:0] data_lat,
  input wire logic banking_en,
  input wire logic parity_en,
  input wire logic [ebes_pkg::DATA_BANKS-1:0] data_ram_error,
  input wire logic [ebes_pkg::DATA_BANKS-1:0] data_bank_sel,
  input wire logic wide_ways,
  input wire logic [ebes_pkg::TAG_WAYS-1:0] tag_ram_error,
  input wire logic [ebes_pkg::TAG_WAYS-1:0] tag_way_sel,
  input wire logic tag_parity_error,
  input wire logic data_parity_error,
  input wire logic err_for_evict,
  input wire logic [ebes_pkg::SLOT_W-1:0] err_slot,
  output logic evict_busy,
  output logic tag_rd,
  output logic data_rd,
  output logic evict_fwd,
  output logic evict_cancel,
  output logic [ebes_pkg::SLOT_W-1:0] done_slot
);
  typedef struct packed {
    ebes_pkg::ebes_state_t state;
    logic [ebes_pkg::SLOT_W-1:0] slot;
    logic tag_seen;
    logic data_seen;
    logic err;
    logic busy;
    logic tag_rd;
    logic data_rd;
    logic fwd;
    logic cancel;
  } ebes_ev_st_t;
  ebes_ev_st_t st_ff;
  ebes_ev_st_t nxt_st;
  ebes_win_if tag_w();
  ebes_win_if data_w();
  logic [ebes_pkg::TAG_WAYS-1:0] way_mask;
  logic ours;
  logic tag_hit;
  logic data_hit;

  ebes_window u_tag_win (.clk(clk), .rst(rst), .w(tag_w));
  ebes_window u_data_win (.clk(clk), .rst(rst), .w(data_w));

  // ---------------------------------------------------------------
  // error qualification
  // ---------------------------------------------------------------
  assign way_mask = wide_ways ? 16'hFFFF : 16'h00FF;
  // errors tagged for another requester or slot are not ours
  assign ours = err_for_evict && (err_slot == st_ff.slot);
  // banked data error only counts on the bank actually read
  assign data_hit = data_w.strobe && ours &&
      (banking_en ? |(data_ram_error & data_bank_sel) : data_ram_error[0]);
  // tag parity ignored unless parity is built; data parity never looked at
  assign tag_hit = tag_w.strobe && ours &&
      (|(tag_ram_error & tag_way_sel & way_mask) || (parity_en && tag_parity_error));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tag_rd = 1'b0;
    nxt_st.data_rd = 1'b0;
    nxt_st.fwd = 1'b0;
    nxt_st.cancel = 1'b0;
    tag_w.start = 1'b0;
    data_w.start = 1'b0;
    tag_w.lat = tag_lat;
    data_w.lat = data_lat;
    case (st_ff.state)
      ebes_pkg::EBES_IDLE: begin
        if (evict_req) begin
          nxt_st.state = ebes_pkg::EBES_READ;
          nxt_st.slot = evict_slot;
          nxt_st.tag_seen = 1'b0;
          nxt_st.data_seen = 1'b0;
          nxt_st.err = 1'b0;
          nxt_st.busy = 1'b1;
          nxt_st.tag_rd = 1'b1;
          nxt_st.data_rd = 1'b1;
          tag_w.start = 1'b1;
          data_w.start = 1'b1;
        end
      end
      ebes_pkg::EBES_READ: begin
        if (tag_w.strobe) begin
          nxt_st.tag_seen = 1'b1;
        end
        if (data_w.strobe) begin
          nxt_st.data_seen = 1'b1;
        end
        if (tag_hit || data_hit) begin
          nxt_st.err = 1'b1;
        end
        if ((st_ff.tag_seen || tag_w.strobe) && (st_ff.data_seen || data_w.strobe)) begin
          nxt_st.state = ebes_pkg::EBES_DONE;
        end
      end
      ebes_pkg::EBES_DONE: begin
        // data_parity_error deliberately unused: write-back must still happen
        nxt_st.cancel = st_ff.err;
        nxt_st.fwd = ~st_ff.err;
        nxt_st.busy = 1'b0;
        nxt_st.state = ebes_pkg::EBES_IDLE;
      end
      default: begin
        nxt_st.state = ebes_pkg::EBES_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign evict_busy = st_ff.busy;
  assign tag_rd = st_ff.tag_rd;
  assign data_rd = st_ff.data_rd;
  assign evict_fwd = st_ff.fwd;
  assign evict_cancel = st_ff.cancel;
  assign done_slot = st_ff.slot;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start;
    st_ff.state == ebes_pkg::EBES_IDLE && evict_req;
  endsequence
  sequence s_both_reads;
    tag_rd && data_rd;
  endsequence
  // a clean read phase: any error flag seen one cycle later must come from a real capture
  sequence s_read_clean;
    st_ff.state == ebes_pkg::EBES_READ && !st_ff.err;
  endsequence

  property p_reads_both;
    @(posedge clk) disable iff (rst) s_start |=> s_both_reads;
  endproperty
  a_reads_both: assert property (p_reads_both) else $error("eviction missed a ram read");

  property p_err_cancels;
    @(posedge clk) disable iff (rst)
      (st_ff.state == ebes_pkg::EBES_READ && (tag_hit || data_hit)) |-> ##[1:9] evict_cancel;
  endproperty
  a_err_cancels: assert property (p_err_cancels) else $error("valid error did not cancel");

  property p_one_outcome;
    @(posedge clk) disable iff (rst) !(evict_fwd && evict_cancel);
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("forwarded and cancelled");

  property p_parity_ignored;
    @(posedge clk) disable iff (rst)
      (st_ff.state == ebes_pkg::EBES_DONE && !st_ff.err) |=> evict_fwd;
  endproperty
  a_parity_ignored: assert property (p_parity_ignored) else $error("clean eviction dropped");

  property p_no_early_sample;
    @(posedge clk) disable iff (rst)
      s_read_clean ##0 (!data_w.strobe && !tag_w.strobe) |=> !st_ff.err;
  endproperty
  a_no_early_sample: assert property (p_no_early_sample) else $error("data error off window");

  property p_foreign_slot;
    @(posedge clk) disable iff (rst)
      s_read_clean ##0 (!err_for_evict || err_slot != st_ff.slot) |=> !st_ff.err;
  endproperty
  a_foreign_slot: assert property (p_foreign_slot) else $error("foreign slot error taken");

  property p_data_window;
    @(posedge clk) disable iff (rst)
      (s_start and (data_lat == 3'h3)) |-> ##4 data_w.strobe;
  endproperty
  a_data_window: assert property (p_data_window) else $error("data sample cycle wrong");

  property p_no_parity;
    @(posedge clk) disable iff (rst)
      s_read_clean ##0 (!parity_en && !data_w.strobe &&
          ((tag_ram_error & tag_way_sel) == 16'h0000)) |=> !st_ff.err;
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("inactive parity cancelled");

  property p_narrow_ways;
    @(posedge clk) disable iff (rst)
      s_read_clean ##0 (!wide_ways && !parity_en && !data_w.strobe &&
          ((tag_ram_error[7:0] & tag_way_sel[7:0]) == 8'h00)) |=> !st_ff.err;
  endproperty
  a_narrow_ways: assert property (p_narrow_ways) else $error("upper ways used");

  property p_bank_one;
    @(posedge clk) disable iff (rst)
      s_read_clean ##0 (!banking_en && !tag_w.strobe && !data_ram_error[0]) |=> !st_ff.err;
  endproperty
  a_bank_one: assert property (p_bank_one) else $error("unbanked upper bit used");
endmodule

// ===== verif/ebes_ram_model.sv
// behavioural tag and data ram arrays answering each eviction read
`timescale 1ns/100ps
module ebes_ram_model (
  input wire logic clk,
  input wire logic tag_rd,
  input wire logic [ebes_pkg::LAT_W-1:0] tag_lat,
  input wire logic [ebes_pkg::LAT_W-1:0] data_lat,
  input wire logic [ebes_pkg::DATA_BANKS-1:0] inj_data,
  input wire logic [ebes_pkg::TAG_WAYS-1:0] inj_tag,
  output logic [ebes_pkg::DATA_BANKS-1:0] data_ram_error,
  output logic [ebes_pkg::TAG_WAYS-1:0] tag_ram_error
);
  logic [2:0] age_ff = 3'h0;
  logic [2:0] phase;
  // phase counts cycles since the read cycle, so latency n answers n cycles after the read
  always_ff @(posedge clk) begin
    if (tag_rd) age_ff <= 3'h1;
    else if (age_ff != 3'h0 && age_ff != 3'h7) age_ff <= age_ff + 3'h1;
  end
  assign phase = tag_rd ? 3'h0 : age_ff;
  // the error is only valid on the latency cycle; elsewhere the lines carry the inverse of the injected value
  assign data_ram_error = (phase == (data_lat == 3'h0 ? 3'h1 : data_lat)) ? inj_data : ~inj_data;
  assign tag_ram_error = (phase == (tag_lat == 3'h0 ? 3'h1 : tag_lat)) ? inj_tag : ~inj_tag;
endmodule

// ===== verif/l2_eviction_error_sampling_tb_top.sv
// self-checking bench for the eviction error sampler
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module l2_eviction_error_sampling_tb_top;
  // flags: tpar pen dpar bank wide for_evict slot_match cancel
  typedef struct packed {
    logic [2:0] tl; logic [2:0] dl; logic [3:0] de; logic [15:0] te; logic [7:0] f;
  } ebes_row_t;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, bk = 1'b0, pen = 1'b0, wd = 1'b0;
  logic tp = 1'b0, dp = 1'b0, efe = 1'b0, busy, trd, drd, fwd, cxl;
  logic [1:0] slot = 2'h0, eslot = 2'h0, dslot;
  logic [2:0] tl = 3'h1, dl = 3'h1;
  logic [3:0] de = 4'h0, dre;
  logic [15:0] te = 16'h0000, tre;
  int num_errors = 0, n_tests = 0;
  ebes_row_t rows[12];
  ebes_evict u_ebes_evict (.clk(clk), .rst(rst), .evict_req(req), .evict_slot(slot),
    .tag_lat(tl), .data_lat(dl), .banking_en(bk), .parity_en(pen), .data_ram_error(dre),
    .data_bank_sel(4'hF), .wide_ways(wd), .tag_ram_error(tre), .tag_way_sel(16'hFFFF),
    .tag_parity_error(tp), .data_parity_error(dp), .err_for_evict(efe), .err_slot(eslot),
    .evict_busy(busy), .tag_rd(trd), .data_rd(drd), .evict_fwd(fwd), .evict_cancel(cxl),
    .done_slot(dslot));
  ebes_ram_model u_ebes_ram_model (.clk(clk), .tag_rd(trd), .tag_lat(tl), .data_lat(dl),
    .inj_data(de), .inj_tag(te), .data_ram_error(dre), .tag_ram_error(tre));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input ebes_row_t r, input logic [1:0] s);
    int n;
    int exp;
    logic [1:0] rd;
    exp = ((r.tl == 3'h0) ? 1 : r.tl) > ((r.dl == 3'h0) ? 1 : r.dl) ?
      ((r.tl == 3'h0) ? 1 : r.tl) + 2 : ((r.dl == 3'h0) ? 1 : r.dl) + 2;
    @(posedge clk);
    {tl, dl, de, te} <= {r.tl, r.dl, r.de, r.te};
    {tp, pen, dp, bk, wd, efe} <= r.f[7:2];
    slot <= s;
    eslot <= r.f[1] ? s : s + 2'h1;
    req <= 1'b1;
    @(posedge clk);
    slot <= s + 2'h1;
    // the read pulses stand only in the cycle right after the take
    #1;
    rd = {trd, drd};
    n = 0;
    do begin
      @(posedge clk);
      req <= 1'b0;
      #1;
      n++;
    end while (!(fwd | cxl) && n < 20);
    if (n >= 20) begin
      num_errors++;
      report_and_stop();
    end else begin
      `CHK("reads", 2'h3, rd)
      `CHK("cancel", r.f[0], cxl)
      `CHK("forward", ~r.f[0], fwd)
      `CHK("cycles", exp, n)
      `CHK("slot", s, dslot)
      `CHK("busy", 1'b0, busy)
    end
  endtask
  initial begin
    rows = '{'{3'h1, 3'h1, 4'h0, 16'h0000, 8'h1E}, '{3'h2, 3'h3, 4'h1, 16'h0000, 8'h1F},
      '{3'h4, 3'h2, 4'h0, 16'h0100, 8'h1F}, '{3'h4, 3'h2, 4'h0, 16'h0100, 8'h16},
      '{3'h3, 3'h2, 4'h2, 16'h0000, 8'h0E}, '{3'h2, 3'h2, 4'h2, 16'h0000, 8'h1F},
      '{3'h3, 3'h1, 4'h0, 16'h0000, 8'hDF}, '{3'h3, 3'h1, 4'h0, 16'h0000, 8'h9E},
      '{3'h1, 3'h2, 4'h0, 16'h0000, 8'h3E}, '{3'h2, 3'h2, 4'h1, 16'h0000, 8'h1A},
      '{3'h2, 3'h2, 4'h1, 16'h0000, 8'h1C}, '{3'h0, 3'h7, 4'h0, 16'h0001, 8'h1F}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset fwd", 1'b0, fwd | cxl)
    foreach (rows[i]) run(rows[i], i[1:0]);
    // reset in mid-eviction must drop it without a verdict
    @(posedge clk);
    req <= 1'b1;
    tl <= 3'h7;
    @(posedge clk);
    req <= 1'b0;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    repeat (9) begin
      @(posedge clk);
      #1;
      `CHK("abort", 3'h0, {busy, fwd, cxl})
    end
    run(rows[1], 2'h3);
    report_and_stop();
  end
endmodule
